// file: src/irsm_pkg.sv
`default_nettype none
package irsm_pkg;
  localparam int NUM_GROUPS = 64;
  localparam int LINES_PER_GROUP = 32;
  localparam int NUM_LINES = NUM_GROUPS * LINES_PER_GROUP;
  localparam int NUM_LEVELS = 4;
  localparam int GROUP_W = 6;
  localparam int LEVEL_W = 2;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  // word indices; byte address is four times the index
  localparam logic [9:0] STAT_BASE_IDX = 10'h0FF;
  localparam logic [9:0] STAT_COUNT = 10'h040;
  localparam logic [9:0] CAUSE3_IDX = 10'h200;
  localparam logic [9:0] CAUSE2_IDX = 10'h204;
  localparam logic [9:0] CAUSE1_IDX = 10'h208;
  localparam logic [9:0] CAUSE0_IDX = 10'h20C;
  localparam logic [31:0] STATUS_RST = 32'h00000000;
  localparam logic [5:0] CAUSE_RST = 6'h00;
  localparam logic [1:0] LVL_INT0 = 2'h0;
  localparam logic [1:0] LVL_INT3 = 2'h3;
  // group and line map
  localparam int GRP_CORE = 0;
  localparam int GRP_PIN = 1;
  localparam int LINE_RTC = 8;
  localparam int LINE_PM = 9;
  localparam int GRP_GPIO = 2;
  localparam int GRP_DMA_CH = 3;
  localparam int GRP_FLASH = 4;
  localparam int GRP_USART0 = 5;
  localparam int GRP_SPI0 = 9;
  localparam int GRP_TWIM0 = 11;
  localparam int GRP_SSC = 13;
  localparam int GRP_TC0 = 14;
  localparam int GRP_ADC = 15;
  localparam int GRP_TC1 = 16;
  localparam int GRP_USB = 17;
  localparam int GRP_SDRAM = 18;
  localparam int GRP_ADAC = 19;
  localparam int GRP_MCI = 20;
  localparam int GRP_AES = 21;
  localparam int GRP_DMA_CTL = 22;
  localparam int GRP_MSI = 26;
  localparam int GRP_TWIS0 = 27;
  localparam int GRP_ECC = 29;
endpackage
`default_nettype wire

// file: src/irsm_status_map.sv
`timescale 1ns/10ps
`default_nettype none
module irsm_status_map (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic core_compare_request,
  input wire logic [7:0] pin_interrupt_unit_req,
  input wire logic rtc_req,
  input wire logic pm_req,
  input wire logic [13:0] gpio_req,
  input wire logic [7:0] peripheral_dma_channels_req,
  input wire logic flash_ctrl_req,
  input wire logic [3:0] usart_req,
  input wire logic [1:0] spi_req,
  input wire logic [1:0] twim_req,
  input wire logic ssc_req,
  input wire logic [2:0] tc0_req,
  input wire logic adc_req,
  input wire logic [2:0] tc1_req,
  input wire logic usb_req,
  input wire logic sdram_req,
  input wire logic audio_dac_req,
  input wire logic mci_req,
  input wire logic aes_req,
  input wire logic [4:0] dma_ctrl_req,
  input wire logic msi_req,
  input wire logic [1:0] twis_req,
  input wire logic flash_error_correction_unit_req,
  input wire logic nmi_req,
  input wire logic [63:0][1:0] group_priority_level,
  output logic sel_valid,
  output logic sel_nmi,
  output logic [1:0] sel_level,
  output logic [5:0] sel_group
);
  localparam int LPG = irsm_pkg::LINES_PER_GROUP;

  logic [irsm_pkg::NUM_LINES-1:0] req_map;
  logic [irsm_pkg::NUM_LINES-1:0] status_ff;
  logic [63:0] grp_req;
  logic [3:0][63:0] lvl_match;
  logic [3:0] lvl_pend;
  logic [3:0][5:0] nxt_cause;
  logic [3:0][5:0] cause_ff;
  logic nmi_ff;
  logic nxt_sel_valid;
  logic [1:0] nxt_sel_level;
  logic [5:0] nxt_sel_group;
  logic sel_valid_ff;
  logic sel_nmi_ff;
  logic [1:0] sel_level_ff;
  logic [5:0] sel_group_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;

  // fixed routing of peripheral requests into the flat line vector
  always_comb begin
    req_map = '0;
    req_map[irsm_pkg::GRP_CORE*LPG] = core_compare_request;
    req_map[irsm_pkg::GRP_PIN*LPG +: 8] = pin_interrupt_unit_req;
    req_map[irsm_pkg::GRP_PIN*LPG + irsm_pkg::LINE_RTC] = rtc_req;
    req_map[irsm_pkg::GRP_PIN*LPG + irsm_pkg::LINE_PM] = pm_req;
    req_map[irsm_pkg::GRP_GPIO*LPG +: 14] = gpio_req;
    req_map[irsm_pkg::GRP_DMA_CH*LPG +: 8] = peripheral_dma_channels_req;
    req_map[irsm_pkg::GRP_FLASH*LPG] = flash_ctrl_req;
    for (int i = 0; i < 4; i++) begin
      req_map[(irsm_pkg::GRP_USART0+i)*LPG] = usart_req[i];
    end
    for (int i = 0; i < 2; i++) begin
      req_map[(irsm_pkg::GRP_SPI0+i)*LPG] = spi_req[i];
      req_map[(irsm_pkg::GRP_TWIM0+i)*LPG] = twim_req[i];
      req_map[(irsm_pkg::GRP_TWIS0+i)*LPG] = twis_req[i];
    end
    req_map[irsm_pkg::GRP_SSC*LPG] = ssc_req;
    req_map[irsm_pkg::GRP_TC0*LPG +: 3] = tc0_req;
    req_map[irsm_pkg::GRP_ADC*LPG] = adc_req;
    req_map[irsm_pkg::GRP_TC1*LPG +: 3] = tc1_req;
    req_map[irsm_pkg::GRP_USB*LPG] = usb_req;
    req_map[irsm_pkg::GRP_SDRAM*LPG] = sdram_req;
    req_map[irsm_pkg::GRP_ADAC*LPG] = audio_dac_req;
    req_map[irsm_pkg::GRP_MCI*LPG] = mci_req;
    req_map[irsm_pkg::GRP_AES*LPG] = aes_req;
    req_map[irsm_pkg::GRP_DMA_CTL*LPG +: 5] = dma_ctrl_req;
    req_map[irsm_pkg::GRP_MSI*LPG] = msi_req;
    req_map[irsm_pkg::GRP_ECC*LPG] = flash_error_correction_unit_req;
  end

  // continuous sampling, no write path exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= '0;
      nmi_ff <= 1'b0;
    end else begin
      status_ff <= req_map;
      nmi_ff <= nmi_req;
    end
  end

  genvar g, l;
  generate
    for (g = 0; g < irsm_pkg::NUM_GROUPS; g++) begin : g_grp
      assign grp_req[g] = |status_ff[g*LPG +: LPG];
      for (l = 0; l < irsm_pkg::NUM_LEVELS; l++) begin : g_lvl
        // one level per group covers all its lines
        assign lvl_match[l][g] = grp_req[g] && (group_priority_level[g] == 2'(l));
      end
    end
    for (l = 0; l < irsm_pkg::NUM_LEVELS; l++) begin : g_pend
      assign lvl_pend[l] = |lvl_match[l];
    end
  endgenerate

  // downward scan so the lowest matching group is left standing
  always_comb begin
    for (int lv = 0; lv < irsm_pkg::NUM_LEVELS; lv++) begin
      nxt_cause[lv] = irsm_pkg::CAUSE_RST;
      for (int gi = irsm_pkg::NUM_GROUPS-1; gi >= 0; gi--) begin
        if (lvl_match[lv][gi]) begin
          nxt_cause[lv] = 6'(gi);
        end
      end
    end
  end

  // highest pending level wins, code 11 above 00
  always_comb begin
    nxt_sel_valid = |lvl_pend;
    nxt_sel_level = irsm_pkg::LVL_INT0;
    nxt_sel_group = irsm_pkg::CAUSE_RST;
    for (int lv = 0; lv < irsm_pkg::NUM_LEVELS; lv++) begin
      if (lvl_pend[lv]) begin
        nxt_sel_level = 2'(lv);
        nxt_sel_group = nxt_cause[lv];
      end
    end
    if (nmi_ff) begin
      nxt_sel_valid = 1'b1;
      nxt_sel_level = irsm_pkg::LVL_INT3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff <= '0;
      sel_valid_ff <= 1'b0;
      sel_nmi_ff <= 1'b0;
      sel_level_ff <= irsm_pkg::LVL_INT0;
      sel_group_ff <= irsm_pkg::CAUSE_RST;
    end else begin
      cause_ff <= nxt_cause;
      sel_valid_ff <= nxt_sel_valid;
      sel_nmi_ff <= nmi_ff;
      sel_level_ff <= nxt_sel_level;
      sel_group_ff <= nxt_sel_group;
    end
  end

  assign sel_valid = sel_valid_ff;
  assign sel_nmi = sel_nmi_ff;
  assign sel_level = sel_level_ff;
  assign sel_group = sel_group_ff;

  // bus decode
  wire [9:0] word_idx = paddr[11:2];
  wire [9:0] stat_off = word_idx - irsm_pkg::STAT_BASE_IDX;
  wire stat_above = (word_idx >= irsm_pkg::STAT_BASE_IDX);
  wire stat_hit = stat_above && (stat_off < irsm_pkg::STAT_COUNT);
  wire [5:0] stat_grp = stat_off[5:0];
  wire c3_hit = (word_idx == irsm_pkg::CAUSE3_IDX);
  wire c2_hit = (word_idx == irsm_pkg::CAUSE2_IDX);
  wire c1_hit = (word_idx == irsm_pkg::CAUSE1_IDX);
  wire c0_hit = (word_idx == irsm_pkg::CAUSE0_IDX);
  wire cause_hit = c3_hit | c2_hit | c1_hit | c0_hit;
  wire map_hit = stat_hit | cause_hit;
  wire [1:0] cause_sel = c3_hit ? 2'h3 : c2_hit ? 2'h2 : c1_hit ? 2'h1 : 2'h0;
  wire [31:0] stat_word = status_ff[{stat_grp, 5'h00} +: 32];
  wire [31:0] cause_word = {26'h0000000, cause_ff[cause_sel]};
  wire [31:0] rd_mux = stat_hit ? stat_word : (cause_hit ? cause_word : irsm_pkg::STATUS_RST);
  wire setup_ph = psel && !penable;

  // read data latched at setup, so a zero-wait access phase presents it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= irsm_pkg::STATUS_RST;
      pslverr_ff <= 1'b0;
    end else if (setup_ph) begin
      prdata_ff <= pwrite ? irsm_pkg::STATUS_RST : rd_mux;
      pslverr_ff <= !map_hit;
    end
  end

  assign prdata = prdata_ff;
  assign pready = psel && penable;
  assign pslverr = pslverr_ff && psel && penable;

  // helper state for checks
  logic [63:0] grp_req_d;
  logic [3:0][63:0] lvl_match_d;
  logic acc_cause_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grp_req_d <= '0;
      lvl_match_d <= '0;
      acc_cause_d <= 1'b0;
    end else begin
      grp_req_d <= grp_req;
      lvl_match_d <= lvl_match;
      acc_cause_d <= setup_ph && !pwrite && cause_hit;
    end
  end
  wire [63:0] below3 = (64'h0000000000000001 << cause_ff[3]) - 64'h0000000000000001;
  wire [63:0] below0 = (64'h0000000000000001 << cause_ff[0]) - 64'h0000000000000001;
  wire [1:0] gpio_lvl = group_priority_level[irsm_pkg::GRP_GPIO];

  // request sampling and line map
  status_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_compare_request |=> status_ff[0])
    else $error("compare request not seen in status");
  status_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    !gpio_req[13] |=> !status_ff[irsm_pkg::GRP_GPIO*32 + 13])
    else $error("idle line reads as pending");
  ecc_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    flash_error_correction_unit_req |=> status_ff[irsm_pkg::GRP_ECC*32])
    else $error("flash correction request not in group 29");
  sample_cont_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (status_ff == $past(req_map)))
    else $error("status not refreshed from lines");
  rtc_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    rtc_req |=> status_ff[irsm_pkg::GRP_PIN*LPG + irsm_pkg::LINE_RTC])
    else $error("rtc request not in group 1 line 8");
  pm_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    pm_req |=> status_ff[irsm_pkg::GRP_PIN*LPG + irsm_pkg::LINE_PM])
    else $error("power request not in group 1 line 9");
  gpio_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    gpio_req[0] |=> status_ff[irsm_pkg::GRP_GPIO*LPG])
    else $error("gpio line 0 not in group 2 line 0");
  dma_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    peripheral_dma_channels_req[7] |=> status_ff[irsm_pkg::GRP_DMA_CH*LPG + 7])
    else $error("dma channel 7 not in group 3 line 7");
  usart_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    usart_req[3] |=> status_ff[(irsm_pkg::GRP_USART0+3)*LPG])
    else $error("fourth usart request not in group 8");
  tc_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    tc1_req[2] |=> status_ff[irsm_pkg::GRP_TC1*LPG + 2])
    else $error("second timer channel 2 not in group 16 line 2");
  dmactl_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    dma_ctrl_req[4] |=> status_ff[irsm_pkg::GRP_DMA_CTL*LPG + 4])
    else $error("dma controller line 4 not in group 22 line 4");
  slave_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    twis_req[1] |=> status_ff[(irsm_pkg::GRP_TWIS0+1)*LPG])
    else $error("second slave request not in group 28");
  grp_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_ff[irsm_pkg::GRP_GPIO*LPG + 13] |-> lvl_match[gpio_lvl][irsm_pkg::GRP_GPIO])
    else $error("gpio line not pending at its group level");

  // cause registers
  cause_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(lvl_pend[3]) |-> lvl_match_d[3][cause_ff[3]])
    else $error("cause group not pending at its level");
  cause_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(lvl_pend[3]) |-> ((lvl_match_d[3] & below3) == 64'h0000000000000000))
    else $error("lower pending group skipped");
  cause_lvl2_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(lvl_pend[2]) |-> lvl_match_d[2][cause_ff[2]])
    else $error("level 2 cause group not pending");
  cause_lvl0_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(lvl_pend[0]) |-> lvl_match_d[0][cause_ff[0]])
    else $error("level 0 cause group not pending");
  cause_low0_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(lvl_pend[0]) |-> ((lvl_match_d[0] & below0) == 64'h0000000000000000))
    else $error("lower pending group skipped at level 0");
  cause_none_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(lvl_pend[0]) |-> cause_ff[0] == irsm_pkg::CAUSE_RST)
    else $error("idle level cause not at its rest value");
  cause_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc_cause_d && penable |-> prdata[31:6] == 26'h0000000)
    else $error("cause upper bits not zero");

  // selection toward the core
  nmi_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    nmi_req |-> ##2 (sel_nmi && sel_valid && sel_level == irsm_pkg::LVL_INT3))
    else $error("nmi did not win");
  nmi_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !nmi_req |-> ##2 !sel_nmi)
    else $error("nmi flag without a request");
  level_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    !nmi_ff && lvl_pend[3] |=> sel_level == irsm_pkg::LVL_INT3 && sel_group == cause_ff[3])
    else $error("highest level not chosen");
  level_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    !nmi_ff && lvl_pend == 4'h1 |=> sel_level == irsm_pkg::LVL_INT0 && sel_group == cause_ff[0])
    else $error("lowest level alone not chosen");
  sel_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !nmi_ff && lvl_pend == 4'h0 |=> !sel_valid && !sel_nmi)
    else $error("selection shown with nothing pending");

  // register bus
  stat_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && stat_hit) ##1 (psel && penable) |->
      prdata == $past(stat_word))
    else $error("status read returns wrong word");
  cause_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && cause_hit) ##1 (psel && penable) |-> prdata == $past(cause_word))
    else $error("cause read returns wrong word");
  write_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && pwrite) ##1 (psel && penable) |-> prdata == irsm_pkg::STATUS_RST)
    else $error("write returned data");
  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !map_hit) ##1 penable |-> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && map_hit) ##1 penable |-> !pslverr)
    else $error("mapped access flagged as error");

  stat_rd_c: cover property (@(posedge pclk) disable iff (!presetn)
    setup_ph && !pwrite && stat_hit ##1 penable && prdata != 32'h00000000);
  stat_wr_c: cover property (@(posedge pclk) disable iff (!presetn)
    setup_ph && pwrite && stat_hit);
  cause_rd_c: cover property (@(posedge pclk) disable iff (!presetn)
    acc_cause_d && penable && prdata != 32'h00000000);
  same_lvl_c: cover property (@(posedge pclk) disable iff (!presetn)
    $countones(lvl_match[2]) > 1);
  nmi_c: cover property (@(posedge pclk) disable iff (!presetn)
    nmi_ff && |lvl_pend);
endmodule // irsm_status_map
`default_nettype wire

// file: testbench/irsm_req_model.sv
`timescale 1ns/10ps
`default_nettype none
// peripherals raise and drop their request lines one pclk after the command, as a flop would
module irsm_req_model (
  input wire logic pclk,
  input wire logic [64:0] cmd,
  output logic [64:0] req
);
  always_ff @(posedge pclk) begin
    req <= cmd;
  end
endmodule // irsm_req_model
`default_nettype wire

// file: testbench/interrupt_request_status_map_tb.sv
`timescale 1ns/10ps
`default_nettype none
module interrupt_request_status_map_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, sel_valid, sel_nmi, er;
  logic [1:0] sel_level;
  logic [5:0] sel_group;
  logic [64:0] cmd = 65'h0;
  logic [64:0] rq;
  logic [63:0][1:0] lv = '0;
  logic [63:0] pat;
  logic [6:0] cs [4];
  logic [63:0] pats [6] = '{64'hFFFFFFFFFFFFFFFF, 64'h8000000000000001, 64'h5555555555555555,
    64'hAAAAAAAAAAAAAAAA, 64'h0000000000000000, 64'h0000000000000000};
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int top;

  always #2.5 pclk = ~pclk;

  irsm_req_model irsm_req_model_inst (.pclk(pclk), .cmd(cmd), .req(rq));

  // request vector is packed group after group, lines in ascending order
  irsm_status_map irsm_status_map_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_compare_request(rq[0]), .pin_interrupt_unit_req(rq[8:1]), .rtc_req(rq[9]),
    .pm_req(rq[10]), .gpio_req(rq[24:11]), .peripheral_dma_channels_req(rq[32:25]),
    .flash_ctrl_req(rq[33]), .usart_req(rq[37:34]), .spi_req(rq[39:38]),
    .twim_req(rq[41:40]), .ssc_req(rq[42]), .tc0_req(rq[45:43]), .adc_req(rq[46]),
    .tc1_req(rq[49:47]), .usb_req(rq[50]), .sdram_req(rq[51]), .audio_dac_req(rq[52]),
    .mci_req(rq[53]), .aes_req(rq[54]), .dma_ctrl_req(rq[59:55]), .msi_req(rq[60]),
    .twis_req(rq[62:61]), .flash_error_correction_unit_req(rq[63]), .nmi_req(rq[64]),
    .group_priority_level(lv), .sel_valid(sel_valid), .sel_nmi(sel_nmi),
    .sel_level(sel_level), .sel_group(sel_group)
  );

  function automatic int wid(input int g);
    case (g)
      1: return 10;
      2: return 14;
      3: return 8;
      14, 16: return 3;
      22: return 5;
      23, 24, 25: return 0;
      default: return (g < 30) ? 1 : 0;
    endcase
  endfunction

  function automatic logic [31:0] exp_st(input int g);
    int off;
    logic [31:0] s;
    off = 0;
    s = 32'h00000000;
    for (int j = 0; j < g; j++) off += wid(j);
    for (int k = 0; k < wid(g); k++) s[k] = pat[off + k];
    return s;
  endfunction

  // bit 6 flags a pending group at level n, low bits give the lowest such group
  function automatic logic [6:0] cause_of(input int n);
    logic [6:0] c;
    c = 7'h00;
    for (int g = 63; g >= 0; g--)
      if (lv[g] === 2'(n) && exp_st(g) != 32'h00000000) c = {1'b1, 6'(g)};
    return c;
  endfunction

  task automatic test_done();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    chk({31'h0, pready}, 32'h1, "pready");
    chk(32'(n), 32'h1, "wait states");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic ee, input string w);
    apb(1'b0, a, 32'h00000000);
    chk(rd, e, w);
    chk({31'h0, er}, {31'h0, ee}, w);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(12'h000, 32'h00000000, 1'b1, "unmapped 000");
    rchk(12'h3F8, 32'h00000000, 1'b1, "below status");
    rchk(12'h4FC, 32'h00000000, 1'b1, "above status");
    rchk(12'h804, 32'h00000000, 1'b1, "between causes");
    for (int p = 0; p < 70; p++) begin
      pat = (p < 64) ? (64'h1 << p) : pats[p - 64];
      for (int g = 0; g < 64; g++) lv[g] <= 2'((g * 3 + p) % 4);
      cmd <= {(p % 5 == 4) || (p == 69), pat};
      repeat (5) @(posedge pclk);
      top = -1;
      for (int n = 0; n < 4; n++) begin
        cs[n] = cause_of(n);
        if (cs[n][6]) top = n;
      end
      chk({30'h0, sel_valid, sel_nmi}, {30'h0, cmd[64] || top >= 0, cmd[64]}, "sel");
      if (cmd[64]) chk({30'h0, sel_level}, 32'h3, "nmi level");
      else if (top >= 0) chk({24'h0, sel_level, sel_group}, {24'h0, 2'(top), cs[top][5:0]},
        "winner");
      if (p == 64 || p == 65) begin
        apb(1'b1, (p == 64) ? 12'h400 : 12'h800, 32'hFFFFFFFF);
        chk({31'h0, er}, 32'h0, "write err");
      end
      for (int g = 0; g < 64; g++)
        rchk(12'h3FC + 12'(4 * g), exp_st(g), 1'b0, "status");
      for (int n = 0; n < 4; n++)
        rchk(12'h830 - 12'(16 * n), {26'h0, cs[n][5:0]}, 1'b0, "cause");
    end
    test_done();
  end
endmodule // interrupt_request_status_map_tb
`default_nettype wire
